// file: verilog/dbgie_pkg.sv
// Purpose: Constants shared by the debug interrupt entry block.
// Assumes: Big-endian bit numbering; bit 0 is the most significant.
// Notes: Bus offsets are word indices times four.
`default_nettype none
package dbgie_pkg;
   // =========================================================
   // Register byte offsets on the Avalon-MM slave.
   localparam logic [4:0] OFS_MSW = 5'h00; // Machine state word.
   localparam logic [4:0] OFS_SRA = 5'h04; // Saved return address.
   localparam logic [4:0] OFS_SMS = 5'h08; // Saved machine state.
   localparam logic [4:0] OFS_BPA = 5'h0C; // Breakpoint address.
   localparam logic [4:0] OFS_DFA = 5'h10; // Data fault address.
   localparam logic [4:0] OFS_DFC = 5'h14; // Data fault cause.
   localparam logic [4:0] OFS_STS = 5'h18; // Status, read only.
   localparam logic [4:0] OFS_CTL = 5'h1C; // Control.
   // =========================================================
   // Machine state word field positions (little-endian index).
   localparam int MSW_LE = 0;   // Endian bit, big-endian bit 31.
   localparam int MSW_RI = 1;   // Recoverable bit, big-endian bit 30.
   localparam int MSW_IP = 6;   // Vector prefix, big-endian bit 25.
   localparam int MSW_ME = 12;  // Machine check enable, bit 19.
   localparam int MSW_ILE = 16; // Interrupt endian, bit 15.
   // Saved machine state fields cleared on entry: bits 1:4, 10:15.
   localparam logic [31:0] SMS_CLR = 32'h783F0000;
   // Low half copied from machine state word bits 16:31.
   localparam logic [31:0] SMS_LOW = 32'h0000FFFF;
   // Saved machine state bit 4 marks a protection violation.
   localparam logic [31:0] SMS_PROT = 32'h08000000;
   // Data fault cause bit 4 (protection) and bit 6 (store).
   localparam logic [31:0] DFC_PROT = 32'h08000000;
   localparam logic [31:0] DFC_STORE = 32'h02000000;
   // =========================================================
   // Vector bases selected by the vector prefix bit.
   localparam logic [31:0] VEC_BASE0 = 32'h00000000;
   localparam logic [31:0] VEC_BASE1 = 32'hFFF00000;
   // Handler offsets.
   localparam logic [31:0] OFF_EMUL = 32'h00001000;
   localparam logic [31:0] OFF_DPROT = 32'h00001400;
   localparam logic [31:0] OFF_DBP = 32'h00001C00;
   localparam logic [31:0] OFF_IBP = 32'h00001D00;
   localparam logic [31:0] OFF_MASK = 32'h00001E00;
   localparam logic [31:0] OFF_NMI = 32'h00001F00;
   localparam logic [31:0] INSN_BYTES = 32'h00000004;
   // =========================================================
   // Reset values.
   localparam logic [31:0] MSW_RST = 32'h00000000;
   localparam logic CTL_RST = 1'b1; // Maskable requests enabled.
   // Cause codes shown in the status register.
   typedef enum logic [2:0]
   {
      CS_NONE = 3'h0,
      CS_IBP = 3'h1,
      CS_DBP = 3'h2,
      CS_MASK = 3'h3,
      CS_NMI = 3'h4,
      CS_DPROT = 3'h5,
      CS_EMUL = 3'h6
   } dbgie_cause_t;
   // Bus answer states, Gray coded.
   typedef enum logic [0:0]
   {
      BS_IDLE = 1'b0,
      BS_ACK = 1'b1
   } dbgie_bus_t;
endpackage
`default_nettype wire

// file: verilog/dbgie_entry.sv
// Purpose: Debug interrupt entry, precise-state and emulation trap logic.
// Assumes: Core pipeline signals are on clk; request pins are asynchronous.
// Notes: Registers reached over Avalon-MM with waitrequest.
`timescale 1ns/100ps
`default_nettype none
module dbgie_entry
   import dbgie_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   // Avalon-MM slave.
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Request pins from the debug port and peripherals.
   input wire logic periph_bp_req,
   input wire logic dport_mask_req,
   input wire logic dport_nmi_req,
   // Core pipeline.
   input wire logic inst_bp_match,
   input wire logic data_bp_match,
   input wire logic [31:0] cur_pc,
   input wire logic [31:0] next_pc,
   input wire logic [31:0] data_ea,
   input wire logic unimpl_insn,
   // Load/store access stream.
   input wire logic ls_valid,
   input wire logic ls_first,
   input wire logic ls_last,
   input wire logic ls_multi,
   input wire logic ls_store,
   input wire logic ls_update,
   input wire logic ls_misaligned,
   input wire logic ls_prot_err,
   // Results toward the core.
   output logic ls_commit,
   output logic base_update_en,
   output logic align_trap,
   output logic entry_pulse,
   output logic [31:0] vector_addr,
   output logic [31:0] machine_state_word,
   output logic saved_state_undefined
);
   // =========================================================
   // State record.
   // Everything the block remembers lives in this one record, so
   // the register process stays one assignment; reset clears it in one and then sets a few fields.
   // The order of the fields carries no meaning.
   typedef struct packed
   {
      logic [1:0] s_periph; // Synchroniser, periph request.
      logic [1:0] s_mask;   // Synchroniser, maskable request.
      logic [1:0] s_nmi;    // Synchroniser, non-maskable request.
      logic p_periph;       // Last synchronised levels.
      logic p_mask;
      logic p_nmi;
      logic boot;           // Set until first cycle after reset.
      logic undef;          // Saved state undefined flag.
      logic mask_en;        // Control: maskable requests allowed.
      logic ls_err;         // Fault seen in current instruction.
      // Architectural copies that software reaches over the bus.
      logic [31:0] msw;
      logic [31:0] sra;
      logic [31:0] sms;
      logic [31:0] bpa;
      logic [31:0] dfa;
      logic [31:0] dfc;
      // Entry results: vector and pulse to the core, cause to status.
      logic [31:0] vec;
      logic entry;
      dbgie_cause_t cause;
      // Bus answer state and the latched read word.
      dbgie_bus_t bus;
      logic [31:0] rdata;
   } dbgie_state_t;

   dbgie_state_t cur_ff; // Registered state.
   dbgie_state_t nxt_st; // Next state.

   // Decoded request events and chosen cause.
   // All of these are combinational and settle within the cycle
   // in which the core or the synchronisers present them.
   logic ev_periph;
   logic ev_mask;
   logic ev_nmi;
   logic ev_align;
   logic ev_prot;
   dbgie_cause_t sel;
   logic [31:0] sel_ofs;
   logic [31:0] sel_sra;
   // Vector base, entry images and the bus request level.
   logic [31:0] base;
   logic [31:0] entry_msw;
   logic [31:0] entry_sms;
   logic bus_req;

   // =========================================================
   // Event decode.
   // Rising edges of the synchronised pins are used so that a
   // request held high enters the handler once, not every cycle.
   // The price is that a request which drops and rises faster
   // than the synchronisers can follow is seen only once.
   always_comb
   begin
      ev_periph = cur_ff.s_periph[1] & ~cur_ff.p_periph;
      ev_nmi = cur_ff.s_nmi[1] & ~cur_ff.p_nmi;
      ev_mask = cur_ff.s_mask[1] & ~cur_ff.p_mask & cur_ff.mask_en;
      // Alignment is checked before the access leaves the core.
      ev_align = ls_valid & ls_misaligned & ~ls_multi;
      // A protection fault counts only when alignment has not
      // already suppressed the access.
      ev_prot = ls_valid & ls_prot_err & ~ev_align;
   end

   // =========================================================
   // Cause priority and saved address selection.
   // Non-maskable port request outranks all; internal
   // breakpoints come before the asynchronous maskable ones.
   // One cause is taken per cycle and the others are dropped, so
   // software must not expect two causes to enter together.
   always_comb
   begin
      sel = CS_NONE;
      sel_ofs = OFF_MASK;
      sel_sra = next_pc;
      if (ev_nmi)
      begin
         sel = CS_NMI;
         sel_ofs = OFF_NMI;
         sel_sra = next_pc;
      end
      else if (inst_bp_match)
      begin
         sel = CS_IBP;
         sel_ofs = OFF_IBP;
         sel_sra = cur_pc;
      end
      else if (data_bp_match)
      begin
         sel = CS_DBP;
         sel_ofs = OFF_DBP;
         sel_sra = cur_pc + INSN_BYTES;
      end
      else if (ev_prot)
      begin
         // Protection faults use their own interrupt, never the
         // architectural data storage one.
         sel = CS_DPROT;
         sel_ofs = OFF_DPROT;
         sel_sra = cur_pc;
      end
      else if (ev_mask | ev_periph)
      begin
         sel = CS_MASK;
         sel_ofs = OFF_MASK;
         sel_sra = next_pc;
      end
      else if (unimpl_insn)
      begin
         sel = CS_EMUL;
         sel_ofs = OFF_EMUL;
         sel_sra = cur_pc;
      end
      else
      begin
         // No cause: nothing is entered this cycle.
         sel = CS_NONE;
      end
   end

   // =========================================================
   // Entry images built from the old machine state word.
   // Both images read cur_ff.msw, so the saved copy is always the
   // value from before the entry changes.
   // The prefix bit picks the base and is kept across entry, so
   // the handler runs from the same half of the map.
   always_comb
   begin
      base = cur_ff.msw[MSW_IP] ? VEC_BASE1 : VEC_BASE0;
      entry_sms = (cur_ff.msw & ~SMS_CLR);
      if (sel == CS_DPROT)
      begin
         // A protection entry also marks the violation.
         entry_sms = entry_sms | SMS_PROT;
      end
      // State word image: every bit cleared except those that the
      // entry keeps or copies.
      entry_msw = MSW_RST;
      entry_msw[MSW_IP] = cur_ff.msw[MSW_IP];
      entry_msw[MSW_ME] = cur_ff.msw[MSW_ME];
      entry_msw[MSW_LE] = cur_ff.msw[MSW_ILE];
   end

   // =========================================================
   // Next-state logic.
   // Every field holds unless a branch below changes it; entry is
   // handled last so that it overrides a bus write.
   always_comb
   begin
      nxt_st = cur_ff;
      bus_req = avs_read | avs_write;
      // Two-flop synchronisers; stage 0 feeds only stage 1.
      nxt_st.s_periph = {cur_ff.s_periph[0], periph_bp_req};
      nxt_st.s_mask = {cur_ff.s_mask[0], dport_mask_req};
      nxt_st.s_nmi = {cur_ff.s_nmi[0], dport_nmi_req};
      // Previous synchronised levels for the edge detectors.
      nxt_st.p_periph = cur_ff.s_periph[1];
      nxt_st.p_mask = cur_ff.s_mask[1];
      nxt_st.p_nmi = cur_ff.s_nmi[1];
      // Boot and entry flags live for one cycle only.
      nxt_st.boot = 1'b0;
      nxt_st.entry = 1'b0;
      // A port request held across reset has reached the second
      // synchroniser stage by now and spoils the saved pair.
      if (cur_ff.boot & (cur_ff.s_mask[1] | cur_ff.s_nmi[1]))
      begin
         nxt_st.undef = 1'b1;
      end

      // Bus access: one wait cycle, answer on the next edge.
      case (cur_ff.bus)
         BS_IDLE:
         begin
            if (bus_req)
            begin
               nxt_st.bus = BS_ACK;
               // Latched now so it stands in the answer cycle.
               case (avs_address)
                  OFS_MSW: nxt_st.rdata = cur_ff.msw;
                  OFS_SRA: nxt_st.rdata = cur_ff.sra;
                  OFS_SMS: nxt_st.rdata = cur_ff.sms;
                  OFS_BPA: nxt_st.rdata = cur_ff.bpa;
                  OFS_DFA: nxt_st.rdata = cur_ff.dfa;
                  OFS_DFC: nxt_st.rdata = cur_ff.dfc;
                  OFS_STS: nxt_st.rdata = {28'h0000000, cur_ff.undef, cur_ff.cause};
                  OFS_CTL: nxt_st.rdata = {31'h00000000, cur_ff.mask_en};
                  default: nxt_st.rdata = 32'h00000000;
               endcase
            end
         end
         BS_ACK:
         begin
            // The write lands on the edge that ends the answer cycle.
            nxt_st.bus = BS_IDLE;
            if (avs_write)
            begin
               case (avs_address)
                  OFS_MSW: nxt_st.msw = avs_writedata;
                  OFS_SRA: nxt_st.sra = avs_writedata;
                  OFS_SMS: nxt_st.sms = avs_writedata;
                  OFS_BPA: nxt_st.bpa = avs_writedata;
                  OFS_DFA: nxt_st.dfa = avs_writedata;
                  OFS_DFC: nxt_st.dfc = avs_writedata;
                  OFS_CTL: nxt_st.mask_en = avs_writedata[0];
                  default: nxt_st.rdata = cur_ff.rdata;
               endcase
            end
         end
         default: nxt_st.bus = BS_IDLE;
      endcase

      // Per-instruction fault tracking for multi-access forms.
      // The flag covers the accesses of one instruction and clears
      // on its last access.
      if (ls_valid)
      begin
         nxt_st.ls_err = (cur_ff.ls_err & ~ls_first) | ls_prot_err | ev_align;
         if (ls_last)
         begin
            nxt_st.ls_err = 1'b0;
         end
      end

      // Interrupt entry wins over a software write in the same
      // cycle, so the handler never sees a stale state word.
      if (sel != CS_NONE)
      begin
         nxt_st.entry = 1'b1;
         nxt_st.cause = sel;
         // Vector, saved pair and new state word load together.
         nxt_st.vec = base | sel_ofs;
         nxt_st.sra = sel_sra;
         nxt_st.sms = entry_sms;
         nxt_st.msw = entry_msw;
         if (sel == CS_DBP)
         begin
            // Fault registers are left alone for breakpoints.
            nxt_st.bpa = data_ea;
         end
         if (sel == CS_DPROT)
         begin
            // Fault address and cause record the data access.
            nxt_st.dfa = data_ea;
            nxt_st.dfc = DFC_PROT | (ls_store ? DFC_STORE : 32'h00000000);
         end
      end
   end

   // =========================================================
   // State register.
   // Synchronous reset; the boot flag marks the first cycle after
   // reset so that a held port request can be recognised.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cur_ff <= '0;
         // The synchronisers keep sampling through reset, so a pin
         // held across it is seen in the first cycle after it.
         cur_ff.s_periph <= nxt_st.s_periph;
         cur_ff.s_mask <= nxt_st.s_mask;
         cur_ff.s_nmi <= nxt_st.s_nmi;
         cur_ff.boot <= 1'b1;
         cur_ff.mask_en <= CTL_RST;
         cur_ff.msw <= MSW_RST;
         cur_ff.cause <= CS_NONE;
         cur_ff.bus <= BS_IDLE;
      end
      else
      begin
         cur_ff <= nxt_st;
      end
   end

   // =========================================================
   // Load/store results.
   // An access commits unless it faults; earlier accesses of a
   // multi-access instruction are never rolled back.
   // Combinational, so the core can gate the access in the same
   // cycle in which it presents it.
   always_comb
   begin
      // Single-access forms have nothing to keep on a fault.
      ls_commit = ls_valid & ~ls_prot_err & ~ev_align;
      align_trap = ev_align;
      // Base write-back only after a clean final access.
      base_update_en = ls_valid & ls_last & ls_update & ~ls_prot_err & ~ev_align
                       & ~(cur_ff.ls_err & ~ls_first);
   end

   // =========================================================
   // Output drive.
   // Waitrequest is combinational so an idle slave stalls a new
   // request at once; data outputs come from flip-flops.
   assign avs_waitrequest = bus_req & (cur_ff.bus != BS_ACK);
   assign avs_readdata = cur_ff.rdata;
   assign entry_pulse = cur_ff.entry;
   assign vector_addr = cur_ff.vec;
   assign machine_state_word = cur_ff.msw;
   assign saved_state_undefined = cur_ff.undef;
endmodule // dbgie_entry
`default_nettype wire

// file: tb/dbgie_props.sv
// Purpose: Port checker for the debug interrupt entry block.
// Assumes: The bench never lets two event sources collide in one cycle.
// Notes: Bound from tb_top; sees only the block's ports.
`timescale 1ns/100ps
`default_nettype none
module dbgie_props
   import dbgie_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic dport_nmi_req,
   input wire logic inst_bp_match,
   input wire logic data_bp_match,
   input wire logic unimpl_insn,
   input wire logic ls_valid,
   input wire logic ls_first,
   input wire logic ls_multi,
   input wire logic ls_misaligned,
   input wire logic ls_prot_err,
   input wire logic ls_commit,
   input wire logic base_update_en,
   input wire logic align_trap,
   input wire logic entry_pulse,
   input wire logic [31:0] vector_addr,
   input wire logic [31:0] machine_state_word
);
   // =========================================================
   // Helpers.
   // Prefix and machine check are the only bits kept on entry.
   localparam logic [31:0] KEEP = (32'h1 << MSW_IP) | (32'h1 << MSW_ME);
   // Vector base as the prefix bit selects it now.
   wire logic [31:0] vb = machine_state_word[MSW_IP] ? VEC_BASE1 : VEC_BASE0;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // =========================================================
   // Properties.
   a_ibp_vector: assert property (inst_bp_match |=> entry_pulse && vector_addr == ($past(vb) | OFF_IBP))
      else $error("instruction breakpoint vector wrong");
   a_dbp_vector: assert property (data_bp_match && !inst_bp_match |=> vector_addr == ($past(vb) | OFF_DBP))
      else $error("data breakpoint vector wrong");
   a_nmi_vector: assert property ($rose(dport_nmi_req) |-> ##[2:6] (entry_pulse && vector_addr[15:0] == OFF_NMI[15:0]))
      else $error("non-maskable request not taken");
   a_emul_vector: assert property (unimpl_insn && !inst_bp_match && !data_bp_match && !ls_valid
      |=> entry_pulse && vector_addr == ($past(vb) | OFF_EMUL)) else $error("emulation trap missing");
   a_msw_entry: assert property (entry_pulse |-> machine_state_word ==
      (($past(machine_state_word) & KEEP) | 32'($past(machine_state_word[MSW_ILE])))) else $error("state word entry wrong");
   a_align_supp: assert property (ls_valid && ls_misaligned && !ls_multi |-> align_trap && !ls_commit)
      else $error("misaligned access not suppressed");
   a_prot_later: assert property (ls_valid && ls_prot_err && !ls_first |-> !ls_commit
      ##1 (entry_pulse && vector_addr[15:0] == OFF_DPROT[15:0])) else $error("protection entry wrong");
   a_upd_keep: assert property (ls_valid && ls_prot_err |-> !base_update_en)
      else $error("base register updated on fault");
   a_multi_commit: assert property (ls_valid && ls_multi && !ls_prot_err |-> ls_commit)
      else $error("clean multi access dropped");
   a_bus_wait: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("bus answer timing wrong");
endmodule // dbgie_props
`default_nettype wire

// file: tb/dbgie_src.sv
// Purpose: Debug port and peripheral request sources.
// Assumes: Each go bit starts one request level.
// Notes: A request is held a few cycles so the core's synchroniser sees it.
`timescale 1ns/100ps
`default_nettype none
module dbgie_src
(
   input wire logic clk,
   input wire logic [2:0] go,
   input wire logic hold,
   output logic periph_bp_req,
   output logic dport_mask_req,
   output logic dport_nmi_req
);
   logic [2:0] pin_ff = 3'h0; // Request levels, bit order periph, mask, nmi.
   logic [3:0] cnt_ff = 4'h0; // Cycles left before the level drops.
   // A real source holds its line for a while; a one-cycle blip could be lost.
   always_ff @(posedge clk)
   begin
      if (go != 3'h0)
      begin
         pin_ff <= go;
         cnt_ff <= 4'h8;
      end
      else if (cnt_ff != 4'h0)
         cnt_ff <= cnt_ff - 4'h1;
      else
         pin_ff <= 3'h0;
   end
   assign periph_bp_req = pin_ff[0];
   assign dport_mask_req = pin_ff[1] | hold;
   assign dport_nmi_req = pin_ff[2];
endmodule // dbgie_src
`default_nettype wire

// file: tb/tb_top.sv
// Purpose: Self-checking bench for dbgie_entry.
// Assumes: One clock at 200 MHz; bus answers after one wait cycle.
// Notes: Reset check first, then event rows, refusal, load/store and a second reset case.
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import dbgie_pkg::*;
;
   // =========================================================
   // Signals.
   typedef struct {int k; logic [31:0] msw; logic [31:0] pc; logic [31:0] off; logic [2:0] cs;} dbgie_row_t;
   localparam logic [31:0] KEEP = (32'h1 << MSW_IP) | (32'h1 << MSW_ME); // Bits kept on entry.
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, cur_pc, next_pc, data_ea, avs_readdata, vector_addr, machine_state_word, q;
   logic avs_read, avs_write, inst_bp_match, data_bp_match, unimpl_insn, ls_valid, ls_first, ls_last;
   logic ls_multi, ls_store, ls_update, ls_misaligned, ls_prot_err, hold, seen;
   logic avs_waitrequest, ls_commit, base_update_en, align_trap, entry_pulse, saved_state_undefined;
   logic periph_bp_req, dport_mask_req, dport_nmi_req;
   logic [2:0] go;
   int n_tests = 0;
   int n_mismatch = 0;
   // Kinds: 0 ibp, 1 dbp, 2 periph, 3 maskable, 4 nmi, 5 unimplemented.
   dbgie_row_t rows [6] = '{'{0, 32'h0001D043, 32'h00002000, OFF_IBP, CS_IBP},
      '{1, 32'hFFFFFFFD, 32'h00004010, OFF_DBP, CS_DBP}, '{2, 32'h00001000, 32'h00000100, OFF_MASK, CS_MASK},
      '{3, 32'h87C0F0F2, 32'h12345678, OFF_MASK, CS_MASK}, '{4, 32'h00010000, 32'h00000200, OFF_NMI, CS_NMI},
      '{5, 32'h00000042, 32'h00000300, OFF_EMUL, CS_EMUL}};
   always #2.5 clk = ~clk;
   dbgie_entry dbgie_entry_i (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
      .avs_waitrequest, .periph_bp_req, .dport_mask_req, .dport_nmi_req, .inst_bp_match, .data_bp_match, .cur_pc,
      .next_pc, .data_ea, .unimpl_insn, .ls_valid, .ls_first, .ls_last, .ls_multi, .ls_store, .ls_update,
      .ls_misaligned, .ls_prot_err, .ls_commit, .base_update_en, .align_trap, .entry_pulse, .vector_addr,
      .machine_state_word, .saved_state_undefined);
   dbgie_src dbgie_src_i (.clk, .go, .hold, .periph_bp_req, .dport_mask_req, .dport_nmi_req);
   // =========================================================
   // Tasks.
   // Compare one value and count it.
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("ERROR at %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   task automatic end_sim();
      $display("Counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // One Avalon-MM access; the request stands until waitrequest is seen low.
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      for (i = 0; i < 50; i++)
      begin
         // Read at the edge itself, before the design updates.
         @(posedge clk);
         if (avs_waitrequest === 1'h0)
            break;
      end
      if (i == 50)
      begin
         n_mismatch++;
         end_sim();
      end
      q = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
   endtask
   // Start one event of the given kind.
   task automatic pulse(input int k);
      @(posedge clk);
      if (k == 0)
         inst_bp_match <= 1'h1;
      else if (k == 1)
         data_bp_match <= 1'h1;
      else if (k == 5)
         unimpl_insn <= 1'h1;
      else
         go[k - 2] <= 1'h1;
      @(posedge clk);
      {inst_bp_match, data_bp_match, unimpl_insn, go} <= 6'h00;
   endtask
   // Bounded wait for an entry; absence is legal for refusal cases.
   task automatic wait_entry();
      seen = 1'h0;
      for (int i = 0; i < 20 && !seen; i++)
      begin
         // The pulse may already stand in the caller's cycle.
         #1;
         seen = (entry_pulse === 1'h1);
         if (!seen)
            @(posedge clk);
      end
   endtask
   // =========================================================
   // Main sequence.
   initial
   begin
      {avs_address, avs_writedata, cur_pc, next_pc, data_ea, go} = '0;
      {avs_read, avs_write, inst_bp_match, data_bp_match, unimpl_insn, ls_valid, ls_first, ls_last} = '0;
      {ls_multi, ls_store, ls_update, ls_misaligned, ls_prot_err, hold} = '0;
      repeat (20) @(posedge clk);
      rst <= 1'h0;
      #1;
      chk(machine_state_word, MSW_RST);
      chk({vector_addr[30:0], entry_pulse}, 32'h0);
      bus(1'h0, OFS_CTL, 32'h0);
      chk(32'(q[0]), 32'(CTL_RST));
      $display("Reset test done");
      foreach (rows[r])
      begin
         bus(1'h1, OFS_MSW, rows[r].msw);
         cur_pc <= rows[r].pc;
         next_pc <= rows[r].pc + INSN_BYTES;
         data_ea <= ~rows[r].pc;
         pulse(rows[r].k);
         wait_entry();
         chk(32'(seen), 32'h1);
         chk(vector_addr, (rows[r].msw[MSW_IP] ? VEC_BASE1 : VEC_BASE0) + rows[r].off);
         chk(machine_state_word, (rows[r].msw & KEEP) | 32'(rows[r].msw[MSW_ILE]));
         bus(1'h0, OFS_SMS, 32'h0);
         chk(q, rows[r].msw & ~SMS_CLR);
         bus(1'h0, OFS_STS, 32'h0);
         chk(32'(q[2:0]), 32'(rows[r].cs));
         bus(1'h0, OFS_SRA, 32'h0);
         if (rows[r].k < 4)
            chk(q, rows[r].k == 0 ? rows[r].pc : rows[r].pc + INSN_BYTES);
         bus(1'h0, OFS_BPA, 32'h0);
         if (rows[r].k == 1)
            chk(q, ~rows[r].pc);
         $display("Event row %0d done", r);
      end
      // Maskable requests are refused while disabled; status stays read only.
      bus(1'h1, OFS_CTL, 32'h0);
      pulse(3);
      wait_entry();
      chk(32'(seen), 32'h0);
      bus(1'h1, OFS_CTL, 32'h1);
      bus(1'h1, OFS_STS, 32'h7);
      bus(1'h0, OFS_STS, 32'h0);
      chk(32'(q[2:0]), 32'(CS_EMUL));
      $display("Refusal test done");
      // Third store access of a multiple faults after two took effect.
      bus(1'h1, OFS_MSW, 32'h0);
      for (int a = 0; a < 3; a++)
      begin
         @(posedge clk);
         {ls_valid, ls_multi, ls_store, ls_update} <= 4'hF;
         ls_first <= (a == 0);
         ls_last <= (a == 2);
         ls_prot_err <= (a == 2);
         data_ea <= 32'h00003000 + 32'(a * 4);
         #1;
         chk(32'(ls_commit), 32'(a != 2));
      end
      chk(32'(base_update_en), 32'h0);
      @(posedge clk);
      {ls_valid, ls_multi, ls_store, ls_update, ls_first, ls_last, ls_prot_err} <= 7'h00;
      wait_entry();
      chk(vector_addr, VEC_BASE0 + OFF_DPROT);
      bus(1'h0, OFS_DFC, 32'h0);
      chk(q, DFC_PROT | DFC_STORE);
      data_ea <= 32'h0000500C;
      pulse(1);
      wait_entry();
      bus(1'h0, OFS_BPA, 32'h0);
      chk(q, 32'h0000500C);
      bus(1'h0, OFS_DFA, 32'h0);
      chk(q, 32'h00003008);
      bus(1'h0, OFS_DFC, 32'h0);
      chk(q, DFC_PROT | DFC_STORE);
      $display("Load store test done");
      // A single misaligned access is suppressed whole.
      @(posedge clk);
      {ls_valid, ls_first, ls_last, ls_misaligned} <= 4'hF;
      #1;
      chk({30'h0, align_trap, ls_commit}, 32'h2);
      // The same access aligned and in update form writes its base back.
      @(posedge clk);
      {ls_misaligned, ls_update} <= 2'h1;
      #1;
      chk({30'h0, base_update_en, ls_commit}, 32'h3);
      @(posedge clk);
      {ls_valid, ls_first, ls_last, ls_misaligned, ls_update} <= 5'h00;
      // A port request held through reset marks saved state undefined.
      hold <= 1'h1;
      rst <= 1'h1;
      repeat (5) @(posedge clk);
      rst <= 1'h0;
      repeat (3) @(posedge clk);
      #1;
      chk(32'(saved_state_undefined), 32'h1);
      hold <= 1'h0;
      bus(1'h0, OFS_STS, 32'h0);
      chk(32'(q[3]), 32'h1);
      $display("Second reset test done");
      end_sim();
   end
endmodule // tb_top
bind dbgie_entry dbgie_props dbgie_props_i (.clk, .rst, .avs_read, .avs_write, .avs_waitrequest, .dport_nmi_req,
   .inst_bp_match, .data_bp_match, .unimpl_insn, .ls_valid, .ls_first, .ls_multi, .ls_misaligned, .ls_prot_err,
   .ls_commit, .base_update_en, .align_trap, .entry_pulse, .vector_addr, .machine_state_word);
`default_nettype wire
